// ### lpmc_pkg.sv
// Purpose: Shared constants and types for the low-power mode controller.
// Assumes: One 125 MHz system clock, byte addresses on the register bus.
// Notes: Functional notes follow.
// Functional notes
// - A wait instruction with deep sleep clear enters sleep at once.
// - Sleep-on-exit set delays sleep until the current handler has returned.
// - Wait-for-interrupt entry wakes on interrupt; wait-for-event entry on an event.
// - Sleep stops only the core clock; everything else keeps running.
// - Interrupt wake services the interrupt; event wake resumes directly.
// - Deep sleep set with standby select clear enters stop at once.
// - In stop the regulator is low power when the low-power bit is one.
// - Stop halts 1.5V domain clocks and both fast oscillators; state is kept.
// - Stop wake latency is oscillator start-up, plus regulator recovery only when the regulator was low power.
// - Deep sleep, standby select and clear wake flag enter standby.
// - Standby ends on wake pin rise, RTC event, reset pin or watchdog.
// - Standby turns the regulator off; core state is lost.
// - Leaving standby costs a chip reset and restarts from reset.
// - Control register bit 0 is regulator low power, bit 1 standby select.
// - Wake pin or RTC alarm event sets the wake-up event flag.
// - Standby flag is set on standby entry, cleared by reset or write one.
// - Writing one to the wake flag clear bit clears it two cycles later.
package lpmc_pkg;
    // Register byte addresses.
    localparam logic [3:0] LPMC_CTRL_ADDR = 4'h0;
    localparam logic [3:0] LPMC_CSTS_ADDR = 4'h4;
    localparam logic [3:0] LPMC_MODE_ADDR = 4'h8;
    // Field positions.
    localparam int LPMC_CTRL_LPREG_BIT = 0;
    localparam int LPMC_CTRL_SBSEL_BIT = 1;
    localparam int LPMC_CTRL_WUCLR_BIT = 2;
    localparam int LPMC_CTRL_SBCLR_BIT = 3;
    localparam int LPMC_CSTS_WUFLG_BIT = 0;
    localparam int LPMC_CSTS_SBY_FLAG_BIT = 1;
    localparam int LPMC_CSTS_WKEN_BIT = 8;
    // Wait cycles before the bus answer; the status register needs one more.
    localparam logic [1:0] LPMC_WAIT_NORMAL = 2'h1;
    localparam logic [1:0] LPMC_WAIT_CSTS = 2'h2;
    // Timing, in ns, and derived cycle counts (least times round up).
    localparam int LPMC_CLK_PERIOD_NS = 8;
    localparam int LPMC_OSC_START_NS = 4000;
    localparam int LPMC_REG_RECOVER_NS = 2000;
    localparam int LPMC_CHIP_RESET_NS = 8000;
    localparam logic [9:0] LPMC_OSC_START_CYC =
        10'((LPMC_OSC_START_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS);
    localparam logic [9:0] LPMC_REG_RECOVER_CYC =
        10'((LPMC_REG_RECOVER_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS);
    localparam logic [9:0] LPMC_CHIP_RESET_CYC =
        10'((LPMC_CHIP_RESET_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS);
    // Wake source indices on the asynchronous pin vector.
    localparam int LPMC_SRC_WAKE_PIN = 0;
    localparam int LPMC_SRC_RTC = 1;
    localparam int LPMC_SRC_RESET_PIN = 2;
    localparam int LPMC_SRC_WDT = 3;
    localparam int LPMC_SRC_NUM = 4;
    // Mode codes shown in the mode register.
    localparam logic [1:0] LPMC_MODE_RUN = 2'h0;
    localparam logic [1:0] LPMC_MODE_SLEEP = 2'h1;
    localparam logic [1:0] LPMC_MODE_STOP = 2'h2;
    localparam logic [1:0] LPMC_MODE_STANDBY = 2'h3;

    typedef enum logic [2:0] {
        LPMC_ST_RUN, LPMC_ST_SLEEP_PEND, LPMC_ST_SLEEP, LPMC_ST_STOP,
        LPMC_ST_STOP_WAKE, LPMC_ST_STANDBY, LPMC_ST_STANDBY_RST
    } lpmc_fsm_t;

    // Signals from the processor core.
    typedef struct packed {
        logic wait_for_interrupt_instr;
        logic wait_for_event_instr;
        logic deep_sleep_select;
        logic sleep_on_exit;
        logic in_handler;
        logic irq_pending;
        logic wake_event;
    } lpmc_core_t;

    // Clock, oscillator, regulator and core controls.
    typedef struct packed {
        logic core_clk_stop;
        logic periph_clk_stop;
        logic int_fast_osc_stop;
        logic ext_fast_osc_stop;
        logic reg_low_power;
        logic reg_off;
        logic chip_reset;
        logic wake_irq;
        logic wake_event;
    } lpmc_power_t;
endpackage

// ### lpmc_sync_edge.sv
// Purpose: Two-flop synchroniser bank with registered rising-edge detect.
// Assumes: Inputs are asynchronous levels held at least two clock cycles.
// Notes: The first flop feeds only the second flop.
`timescale 1ns/1ns
module lpmc_sync_edge
    import lpmc_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] rise;
    } lpmc_sync_t;

    lpmc_sync_t s_reg;
    lpmc_sync_t s_next;

    // Each lane shifts through meta, sync and prev; the edge is taken late.
    always_comb begin
        s_next = s_reg;
        for (int i = 0; i < WIDTH; i++) begin
            s_next.meta[i] = async_in[i];
            s_next.sync[i] = s_reg.meta[i];
            s_next.prev[i] = s_reg.sync[i];
            s_next.rise[i] = s_reg.sync[i] & ~s_reg.prev[i];
        end
    end

    // Synchronous reset keeps the bank quiet right after release.
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level_out = s_reg.sync;
    assign rise_out = s_reg.rise;
endmodule // lpmc_sync_edge

// ### lpmc_ctrl.sv
// Purpose: Low-power mode sequencer with an Avalon-MM register slave.
// Assumes: Core signals share core_clk_in; wake pins are asynchronous.
// Notes: Clock and regulator controls are registered levels.
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module lpmc_ctrl
    import lpmc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire lpmc_core_t core_in,
    input wire logic wakeup_pin_in,
    input wire logic rtc_event_in,
    input wire logic external_reset_pin_n_in,
    input wire logic independent_watchdog_in,
    output lpmc_power_t power_out,
    output logic [1:0] mode_out
);
    typedef struct packed {
        lpmc_fsm_t fsm;
        logic event_entry;
        logic [9:0] cnt;
        logic stop_regulator_low_power;
        logic standby_select;
        logic wakeup_pin_enable;
        logic wakeup_event_flag;
        logic standby_flag;
        logic [1:0] wuclr_pipe;
        logic waitreq;
        logic [1:0] bus_cnt;
        logic [31:0] rdata;
        lpmc_power_t pwr;
        logic [1:0] mode;
    } lpmc_regs_t;

    lpmc_regs_t st_reg;
    lpmc_regs_t st_next;
    logic [LPMC_SRC_NUM-1:0] src_level;
    logic [LPMC_SRC_NUM-1:0] src_rise;
    logic [LPMC_SRC_NUM-1:0] src_async;
    logic wait_req;
    logic accept;
    logic ctrl_wr;
    logic wu_set;
    logic wu_clr_req;
    logic sb_clr_req;
    logic standby_exit;
    logic wake_now;

    // Mode code of a sequencer state, used for the bus and the mode output.
    function automatic logic [1:0] lpmc_mode_of(input lpmc_fsm_t f);
        unique case (f)
            LPMC_ST_RUN, LPMC_ST_SLEEP_PEND: lpmc_mode_of = LPMC_MODE_RUN;
            LPMC_ST_SLEEP: lpmc_mode_of = LPMC_MODE_SLEEP;
            LPMC_ST_STOP, LPMC_ST_STOP_WAKE: lpmc_mode_of = LPMC_MODE_STOP;
            LPMC_ST_STANDBY, LPMC_ST_STANDBY_RST: lpmc_mode_of = LPMC_MODE_STANDBY;
        endcase
    endfunction

    // Reset pin is inverted ahead of the synchroniser so every lane is active high.
    assign src_async[LPMC_SRC_WAKE_PIN] = wakeup_pin_in;
    assign src_async[LPMC_SRC_RTC] = rtc_event_in;
    assign src_async[LPMC_SRC_RESET_PIN] = ~external_reset_pin_n_in;
    assign src_async[LPMC_SRC_WDT] = independent_watchdog_in;

    lpmc_sync_edge #(
        .WIDTH(LPMC_SRC_NUM)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .async_in(src_async),
        .level_out(src_level),
        .rise_out(src_rise)
    );

    // Request decode; a write takes effect only on the cycle it is answered.
    assign wait_req = core_in.wait_for_interrupt_instr | core_in.wait_for_event_instr;
    assign accept = !st_reg.waitreq && (avs_read_in || avs_write_in);
    assign ctrl_wr = accept && avs_write_in && avs_address_in == LPMC_CTRL_ADDR
        && avs_byteenable_in[0];
    assign wu_clr_req = ctrl_wr && avs_writedata_in[LPMC_CTRL_WUCLR_BIT];
    assign sb_clr_req = ctrl_wr && avs_writedata_in[LPMC_CTRL_SBCLR_BIT];
    // A wake pin rise counts only while the pin is enabled as a wake source.
    assign wu_set = (src_rise[LPMC_SRC_WAKE_PIN] && st_reg.wakeup_pin_enable)
        || src_rise[LPMC_SRC_RTC];
    assign standby_exit = (src_rise[LPMC_SRC_WAKE_PIN] && st_reg.wakeup_pin_enable)
        || src_rise[LPMC_SRC_RTC] || src_level[LPMC_SRC_RESET_PIN]
        || src_level[LPMC_SRC_WDT];
    assign wake_now = st_reg.event_entry ? core_in.wake_event : core_in.irq_pending;

    // Next-state logic for the sequencer, the flags and the bus slave.
    always_comb begin
        st_next = st_reg;
        st_next.pwr.wake_irq = 1'b0;
        st_next.pwr.wake_event = 1'b0;
        st_next.wuclr_pipe = {st_reg.wuclr_pipe[0], wu_clr_req};

        // Flags: a set in the same cycle as a clear wins.
        st_next.wakeup_event_flag = wu_set
            || (st_reg.wakeup_event_flag && !st_reg.wuclr_pipe[1]);
        st_next.standby_flag = st_reg.standby_flag && !sb_clr_req;

        unique case (st_reg.fsm)
            LPMC_ST_RUN: begin
                if (wait_req) begin
                    st_next.event_entry = core_in.wait_for_event_instr;
                    if (!core_in.deep_sleep_select) begin
                        // Other bits are ignored when deep sleep is clear.
                        if (core_in.sleep_on_exit && core_in.in_handler) begin
                            st_next.fsm = LPMC_ST_SLEEP_PEND;
                        end else begin
                            st_next.fsm = LPMC_ST_SLEEP;
                        end
                    end else if (!st_reg.standby_select) begin
                        st_next.fsm = LPMC_ST_STOP;
                    end else if (!st_reg.wakeup_event_flag) begin
                        st_next.fsm = LPMC_ST_STANDBY;
                        st_next.standby_flag = 1'b1;
                    end
                end
            end
            LPMC_ST_SLEEP_PEND: begin
                // Sleep begins once the handler has returned.
                if (!core_in.in_handler) begin
                    st_next.fsm = LPMC_ST_SLEEP;
                end
            end
            LPMC_ST_SLEEP: begin
                // No added delay: wake is reported the cycle after the cause.
                if (wake_now) begin
                    st_next.fsm = LPMC_ST_RUN;
                    st_next.pwr.wake_irq = !st_reg.event_entry;
                    st_next.pwr.wake_event = st_reg.event_entry;
                end
            end
            LPMC_ST_STOP: begin
                if (wake_now) begin
                    st_next.fsm = LPMC_ST_STOP_WAKE;
                    // Recovery from low power only costs time if it was used.
                    st_next.cnt = st_reg.stop_regulator_low_power
                        ? LPMC_OSC_START_CYC + LPMC_REG_RECOVER_CYC
                        : LPMC_OSC_START_CYC;
                end
            end
            LPMC_ST_STOP_WAKE: begin
                st_next.cnt = st_reg.cnt - 10'h001;
                if (st_reg.cnt == 10'h001) begin
                    st_next.fsm = LPMC_ST_RUN;
                    st_next.pwr.wake_irq = !st_reg.event_entry;
                    st_next.pwr.wake_event = st_reg.event_entry;
                end
            end
            LPMC_ST_STANDBY: begin
                if (standby_exit) begin
                    st_next.fsm = LPMC_ST_STANDBY_RST;
                    st_next.cnt = LPMC_CHIP_RESET_CYC;
                    // Control register is lost with the 1.5V domain.
                    st_next.stop_regulator_low_power = 1'b0;
                    st_next.standby_select = 1'b0;
                end
            end
            LPMC_ST_STANDBY_RST: begin
                st_next.cnt = st_reg.cnt - 10'h001;
                if (st_reg.cnt == 10'h001) begin
                    st_next.fsm = LPMC_ST_RUN;
                end
            end
        endcase

        // Register writes land on the answered cycle, ahead of the power controls,
        // so that a new regulator bit never lags one cycle behind the output.
        if (ctrl_wr) begin
            st_next.stop_regulator_low_power =
                avs_writedata_in[LPMC_CTRL_LPREG_BIT];
            st_next.standby_select = avs_writedata_in[LPMC_CTRL_SBSEL_BIT];
        end
        if (accept && avs_write_in && avs_address_in == LPMC_CSTS_ADDR
            && avs_byteenable_in[1]) begin
            st_next.wakeup_pin_enable = avs_writedata_in[LPMC_CSTS_WKEN_BIT];
        end

        // Clock and regulator controls follow the next state.
        st_next.pwr.core_clk_stop = st_next.fsm != LPMC_ST_RUN
            && st_next.fsm != LPMC_ST_SLEEP_PEND;
        st_next.pwr.periph_clk_stop = st_next.fsm inside {LPMC_ST_STOP, LPMC_ST_STOP_WAKE,
            LPMC_ST_STANDBY, LPMC_ST_STANDBY_RST};
        st_next.pwr.int_fast_osc_stop = st_next.fsm inside {LPMC_ST_STOP,
            LPMC_ST_STANDBY};
        st_next.pwr.ext_fast_osc_stop = st_next.fsm inside {LPMC_ST_STOP,
            LPMC_ST_STOP_WAKE, LPMC_ST_STANDBY};
        st_next.pwr.reg_low_power = st_next.fsm == LPMC_ST_STOP
            && st_next.stop_regulator_low_power;
        st_next.pwr.reg_off = st_next.fsm == LPMC_ST_STANDBY;
        st_next.pwr.chip_reset = st_next.fsm == LPMC_ST_STANDBY_RST;
        st_next.mode = lpmc_mode_of(st_next.fsm);

        // Bus timing: one wait cycle, two for the status register.
        if (!st_reg.waitreq) begin
            st_next.waitreq = 1'b1;
            st_next.bus_cnt = 2'h0;
        end else if (avs_read_in || avs_write_in) begin
            if (st_reg.bus_cnt == ((avs_address_in == LPMC_CSTS_ADDR)
                ? LPMC_WAIT_CSTS : LPMC_WAIT_NORMAL) - 2'h1) begin
                st_next.waitreq = 1'b0;
                st_next.bus_cnt = 2'h0;
                st_next.rdata = 32'h0000_0000;
                // Clear bits read as zero; unmapped addresses read zero.
                unique case (avs_address_in)
                    LPMC_CTRL_ADDR: begin
                        st_next.rdata[LPMC_CTRL_LPREG_BIT] = st_reg.stop_regulator_low_power;
                        st_next.rdata[LPMC_CTRL_SBSEL_BIT] = st_reg.standby_select;
                    end
                    LPMC_CSTS_ADDR: begin
                        st_next.rdata[LPMC_CSTS_WUFLG_BIT] = st_reg.wakeup_event_flag;
                        st_next.rdata[LPMC_CSTS_SBY_FLAG_BIT] = st_reg.standby_flag;
                        st_next.rdata[LPMC_CSTS_WKEN_BIT] = st_reg.wakeup_pin_enable;
                    end
                    LPMC_MODE_ADDR: begin
                        st_next.rdata[1:0] = lpmc_mode_of(st_reg.fsm);
                    end
                    default: begin
                        st_next.rdata = 32'h0000_0000;
                    end
                endcase
            end else begin
                st_next.bus_cnt = st_reg.bus_cnt + 2'h1;
            end
        end else begin
            st_next.bus_cnt = 2'h0;
        end
    end

    // Single register stage; rstn_in stands for power-on reset of the flags.
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st_reg <= '0;
            st_reg.fsm <= LPMC_ST_RUN;
            st_reg.waitreq <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata_out = st_reg.rdata;
    assign avs_waitrequest_out = st_reg.waitreq;
    assign power_out = st_reg.pwr;
    assign mode_out = st_reg.mode;

    default clocking lpmc_cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);

    // Sleep entry is immediate and ignores the standby and regulator bits.
    AST_SLEEP_ENTRY: assert property (
        st_reg.fsm == LPMC_ST_RUN && wait_req && !core_in.deep_sleep_select
        && !(core_in.sleep_on_exit && core_in.in_handler)
        |=> power_out.core_clk_stop && mode_out == LPMC_MODE_SLEEP)
        else $error("sleep not entered on wait");
    AST_SLEEP_ON_EXIT: assert property (
        st_reg.fsm == LPMC_ST_RUN && wait_req && !core_in.deep_sleep_select
        && core_in.sleep_on_exit && core_in.in_handler
        |=> !power_out.core_clk_stop ##0 st_reg.fsm == LPMC_ST_SLEEP_PEND)
        else $error("sleep entered inside handler");
    AST_SLEEP_CLOCKS: assert property (
        mode_out == LPMC_MODE_SLEEP |-> !power_out.periph_clk_stop
        && !power_out.int_fast_osc_stop && !power_out.reg_off)
        else $error("sleep stopped more than core clock");
    AST_SLEEP_WAKE: assert property (
        st_reg.fsm == LPMC_ST_SLEEP && !st_reg.event_entry && core_in.irq_pending
        |=> mode_out == LPMC_MODE_RUN && power_out.wake_irq && !power_out.wake_event)
        else $error("interrupt wake from sleep wrong");
    AST_STOP_ENTRY: assert property (
        st_reg.fsm == LPMC_ST_RUN && wait_req && core_in.deep_sleep_select
        && !st_reg.standby_select |=> mode_out == LPMC_MODE_STOP
        && power_out.ext_fast_osc_stop && power_out.int_fast_osc_stop
        && power_out.periph_clk_stop)
        else $error("stop not entered");
    AST_STOP_REG: assert property (
        st_reg.fsm == LPMC_ST_STOP |-> power_out.reg_low_power
        == st_reg.stop_regulator_low_power)
        else $error("stop regulator mode wrong");
    AST_STOP_LATENCY: assert property (
        $rose(st_reg.fsm == LPMC_ST_STOP_WAKE) |-> st_reg.cnt == (
        st_reg.stop_regulator_low_power ? LPMC_OSC_START_CYC + LPMC_REG_RECOVER_CYC
        : LPMC_OSC_START_CYC))
        else $error("stop wake latency wrong");
    AST_STANDBY_ENTRY: assert property (
        st_reg.fsm == LPMC_ST_RUN && wait_req && core_in.deep_sleep_select
        && st_reg.standby_select && !st_reg.wakeup_event_flag
        |=> power_out.reg_off && st_reg.standby_flag)
        else $error("standby not entered");
    AST_STANDBY_EXIT: assert property (
        st_reg.fsm == LPMC_ST_STANDBY && standby_exit
        |=> power_out.chip_reset && !power_out.reg_off)
        else $error("standby exit missed");
    AST_STANDBY_RESET: assert property (
        $rose(power_out.chip_reset) |-> st_reg.cnt == LPMC_CHIP_RESET_CYC
        && !st_reg.standby_select && !power_out.wake_irq)
        else $error("standby reset sequence wrong");
    AST_CTRL_WRITE: assert property (
        ctrl_wr |=> st_reg.stop_regulator_low_power == $past(avs_writedata_in[0])
        && st_reg.standby_select == $past(avs_writedata_in[1]))
        else $error("control bits not written");
    AST_WU_SET: assert property (
        wu_set |=> st_reg.wakeup_event_flag)
        else $error("wake flag not set");
    AST_SB_FLAG_HOLD: assert property (
        st_reg.standby_flag && !sb_clr_req |=> st_reg.standby_flag)
        else $error("standby flag lost");
    AST_WU_CLEAR: assert property (
        wu_clr_req ##1 (!wu_set) [*2] |=> !st_reg.wakeup_event_flag)
        else $error("wake flag not cleared two cycles after write");
endmodule // lpmc_ctrl

// ### lpmc_core_model.sv
// Purpose: Behavioural processor core feeding wait and wake signals.
// Assumes: The bench gives wait requests as one-cycle pulses.
// Notes: A halted core cannot execute, so it issues no wait then.
`timescale 1ns/1ns
module lpmc_core_model
    import lpmc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [6:0] req_in,
    input wire lpmc_power_t power_in,
    output lpmc_core_t core_out
);
    logic halted;
    // A stopped core clock or a chip reset freezes instruction issue.
    assign halted = power_in.core_clk_stop | power_in.chip_reset;
    // Requests map bit for bit; the two wait bits are gated by the halt.
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            core_out <= '0;
        end else begin
            core_out <= lpmc_core_t'(req_in & {~halted, ~halted, 5'h1F});
        end
    end
endmodule // lpmc_core_model

// ### tb_low_power_mode_controller.sv
// Purpose: Self-checking bench for the low-power mode controller.
// Assumes: The core model stands in for the processor.
// Notes: Expected modes come from a small mode model or from fixed values, not the design.
`timescale 1ns/1ns
module tb_low_power_mode_controller;
    import lpmc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic [6:0] req = 7'h00;
    logic [3:0] src = 4'h0;
    lpmc_core_t core;
    lpmc_power_t pwr;
    logic [1:0] mode;
    logic [31:0] d;
    logic [7:0] rnd = 8'h5F;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    int nw;
    // Half period of 4 ns gives 125 MHz.
    always #4 clk = ~clk;
    lpmc_core_model core_u (.core_clk_in(clk), .rstn_in(rstn), .req_in(req),
        .power_in(pwr), .core_out(core));
    lpmc_ctrl dut_u (.core_clk_in(clk), .rstn_in(rstn), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .core_in(core), .wakeup_pin_in(src[0]), .rtc_event_in(src[1]),
        .external_reset_pin_n_in(~src[2]), .independent_watchdog_in(src[3]),
        .power_out(pwr), .mode_out(mode));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Mode model: deep sleep, standby select and wake flag pick the mode.
    function automatic logic [31:0] e_mode(input int dp, input int sb, input int wf);
        if (dp == 0) return 32'h1;
        if (sb == 0) return 32'h2;
        return (wf != 0) ? 32'h0 : 32'h3;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon cycle; the request holds until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
        int t;
        t = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wd <= v;
        do begin
            @(posedge clk);
            t++;
        end while (wreq !== 1'b0 && t < 20);
        d = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        chk(32'(t < 20), 32'h1);
    endtask
    task automatic lvl(input logic [6:0] b, input logic v);
        @(posedge clk);
        req <= v ? (req | b) : (req & ~b);
    endtask
    // The core sees a request one edge later, the controller one more.
    task automatic pulse(input logic [6:0] b);
        lvl(b, 1'b1);
        lvl(b, 1'b0);
        repeat (2) @(posedge clk);
    endtask
    task automatic wait_rnd();
        rnd = lfsr(rnd);
        repeat (rnd[3:0]) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // A hang counts as a mismatch and still ends in the verdict.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, LPMC_CTRL_ADDR, 32'h0);
        chk(d, 32'h0);
        bus(1'b0, 4'hC, 32'h0);
        chk(d, 32'h0);
        bus(1'b1, LPMC_CTRL_ADDR, 32'h3);
        bus(1'b0, LPMC_CTRL_ADDR, 32'h0);
        chk(32'(d[1:0]), 32'h3);
        // Sleep is chosen with deep sleep clear although standby is selected.
        pulse(7'h40);
        chk(32'(mode), e_mode(0, 1, 0));
        chk(32'({pwr[8:5], pwr.reg_off}), 32'h10);
        wait_rnd();
        lvl(7'h02, 1'b1);
        repeat (3) @(posedge clk);
        chk(32'({mode, pwr.wake_irq, pwr.wake_event}), 32'h2);
        @(posedge clk);
        chk(32'(pwr.wake_irq), 32'h0);
        lvl(7'h02, 1'b0);
        // Sleep-on-exit inside a handler waits for the handler to return.
        lvl(7'h0C, 1'b1);
        pulse(7'h20);
        chk(32'(pwr.core_clk_stop), 32'h0);
        lvl(7'h04, 1'b0);
        repeat (4) @(posedge clk);
        chk(32'(mode), 32'h1);
        wait_rnd();
        lvl(7'h01, 1'b1);
        repeat (3) @(posedge clk);
        chk(32'({mode, pwr.wake_irq, pwr.wake_event}), 32'h1);
        lvl(7'h09, 1'b0);
        // Stop with both regulator settings; wake time follows the setting.
        lvl(7'h10, 1'b1);
        for (int lp = 1; lp >= 0; lp--) begin
            bus(1'b1, LPMC_CTRL_ADDR, {rnd, 20'h0, 4'(lp)});
            pulse(7'h20);
            chk(32'(mode), e_mode(1, 0, 0));
            chk(32'({pwr[8:5], pwr.reg_low_power, pwr.reg_off}), 32'(60 + 2 * lp));
            lvl(7'h01, 1'b1);
            nw = 3 + int'(LPMC_OSC_START_CYC) + lp * int'(LPMC_REG_RECOVER_CYC);
            n = 0;
            while (mode !== 2'h0 && n < 2000) begin
                @(posedge clk);
                n++;
            end
            chk(32'(n >= nw - 1 && n <= nw + 1), 32'h1);
            lvl(7'h01, 1'b0);
        end
        // Standby left by each source in turn; every exit is a chip reset.
        bus(1'b1, LPMC_CSTS_ADDR, 32'h100);
        for (int i = 0; i < LPMC_SRC_NUM; i++) begin
            if (i == 1) begin
                bus(1'b1, LPMC_CTRL_ADDR, 32'h2);
                pulse(7'h40);
                chk(32'(mode), e_mode(1, 1, 1));
            end
            bus(1'b1, LPMC_CTRL_ADDR, 32'h6);
            repeat (3) @(posedge clk);
            pulse(7'h40);
            chk(32'(mode), e_mode(1, 1, 0));
            chk(32'({pwr.reg_off, pwr.chip_reset}), 32'h2);
            wait_rnd();
            src <= 4'(1 << i);
            n = 0;
            while (pwr.chip_reset !== 1'b1 && n < 50) begin
                @(posedge clk);
                n++;
            end
            chk(32'(n < 50), 32'h1);
            src <= 4'h0;
            n = 0;
            while (pwr.chip_reset === 1'b1 && n < 2000) begin
                @(posedge clk);
                n++;
            end
            nw = int'(LPMC_CHIP_RESET_CYC);
            chk(32'(n >= nw - 1 && n <= nw + 1), 32'h1);
            chk(32'(mode), 32'h0);
            bus(1'b0, LPMC_CTRL_ADDR, 32'h0);
            chk(32'(d[1:0]), 32'h0);
            bus(1'b0, LPMC_CSTS_ADDR, 32'h0);
            chk(d & 32'h103, 32'h102 | 32'(i < 2));
        end
        bus(1'b1, LPMC_CTRL_ADDR, 32'h8);
        bus(1'b0, LPMC_CSTS_ADDR, 32'h0);
        chk(32'(d[1]), 32'h0);
        // An alarm in run mode sets the wake flag, so the clear below has work to do.
        src <= 4'h2;
        repeat (5) @(posedge clk);
        src <= 4'h0;
        bus(1'b0, LPMC_CSTS_ADDR, 32'h0);
        chk(32'(d[0]), 32'h1);
        bus(1'b1, LPMC_CTRL_ADDR, 32'h4);
        bus(1'b0, LPMC_CSTS_ADDR, 32'h0);
        chk(32'(d[0]), 32'h0);
        finish_test();
    end
endmodule // tb_low_power_mode_controller
